// ==== verilog/tec8_map.svh ====
/*
 holds the register map, field positions and reset values of the 8-bit
 timer/event counter as macros.
 assumes it is included by its bare name before the package and modules.
*/
`ifndef TEC8_MAP_SVH
`define TEC8_MAP_SVH
`define TEC8_OFS_COUNT 3'h0
`define TEC8_OFS_CTRL 3'h1
`define TEC8_OFS_IRQ_STAT 3'h2
`define TEC8_OFS_IRQ_CLR 3'h3
`define TEC8_OFS_IRQ_EN 3'h4
`define TEC8_CTL_MODE_HI 7
`define TEC8_CTL_MODE_LO 6
`define TEC8_CTL_SRC 5
`define TEC8_CTL_EN 4
`define TEC8_CTL_POL 3
`define TEC8_CTL_PSC_HI 2
`define TEC8_CTL_PSC_LO 0
`define TEC8_CTL_RESET 8'h08
`define TEC8_CNT_RESET 8'h00
`define TEC8_CNT_FULL 8'hff
`define TEC8_CNT_ONE 8'h01
`define TEC8_DATA_ZERO 8'h00
`define TEC8_IRQ_OVF 0
`define TEC8_IRQ_PWD 1
`define TEC8_IRQ_HI 1
`define TEC8_IRQ_RESET 2'h0
`define TEC8_PSC_W 7
`define TEC8_PSC_RESET 7'h00
`define TEC8_PSC_ONE 7'h01
`define TEC8_DIV_N 8
`endif

// ==== verilog/tec8_pkg.sv ====
/*
 holds the mode and state types of the timer/event counter.
 assumes nothing of its surroundings.
*/
package tec8_pkg;
   // operating mode field codes
   typedef enum logic [1:0] {
      TEC8_MODE_NONE = 2'h0,
      TEC8_MODE_EVENT = 2'h1,
      TEC8_MODE_TIMER = 2'h2,
      TEC8_MODE_PULSE = 2'h3
   } tec8_mode_t;
   // pulse width measurement states
   typedef enum logic [1:0] {
      TEC8_PW_WAIT = 2'b01,
      TEC8_PW_RUN = 2'b10
   } tec8_pw_state_t;
endpackage

// ==== verilog/tec8_sync.sv ====
/*
 holds a two flip-flop synchroniser for a group of asynchronous inputs.
 assumes inputs are levels that stay stable for at least two clocks.
*/
`timescale 1ns/10ps
module tec8_sync #(
   parameter int WIDTH = 2
) (
   input wire logic clock,
   input wire logic rst_b,
   input wire logic [WIDTH-1:0] async_in,
   output logic [WIDTH-1:0] sync_out
);
   logic [WIDTH-1:0] meta_reg;
   logic [WIDTH-1:0] meta_next;
   logic [WIDTH-1:0] sync_next;

   if (WIDTH < 1) begin : g_bad_width
      $error("tec8_sync needs at least one bit");
   end

   // first stage feeds only the second stage
   always_comb begin
      meta_next = async_in;
      sync_next = meta_reg;
   end

   // both stages clear on reset
   always_ff @(posedge clock) begin
      if (!rst_b) begin
         meta_reg <= '0;
         sync_out <= '0;
      end else begin
         meta_reg <= meta_next;
         sync_out <= sync_next;
      end
   end
endmodule // tec8_sync

// ==== verilog/tec8_top.sv ====
/*
 holds the 8-bit timer/event counter: prescaler, counter with preload,
 pulse width measurement and a small interrupt block on a plain register port.
 assumes a single 40 MHz clock, a synchronous master on the register port,
 and asynchronous sub clock and event pin levels.
*/
// Design decisions made here: the plain strobed port and the register offsets.
`timescale 1ns/10ps
`include "tec8_map.svh"
module tec8_top
   import tec8_pkg::*;
#(
   parameter int ADDR_W = 3
) (
   input wire logic clock,
   input wire logic rst_b,
   input wire logic [ADDR_W-1:0] bus_addr,
   input wire logic [7:0] bus_wdata,
   input wire logic bus_wr,
   input wire logic bus_rd,
   output logic [7:0] bus_rdata,
   input wire logic sub_clock,
   input wire logic event_input_pin,
   output logic irq
);
   logic sub_s;
   logic pin_s;
   logic sub_prev_reg;
   logic sub_prev_next;
   logic pin_prev_reg;
   logic pin_prev_next;
   logic pin_rise;
   logic pin_fall;
   logic sub_fall;
   logic tp_tick;
   logic [`TEC8_PSC_W-1:0] presc_reg;
   logic [`TEC8_PSC_W-1:0] presc_next;
   logic [`TEC8_DIV_N-1:0] fall_vec;
   logic int_tick;
   logic [7:0] count_value_reg;
   logic [7:0] count_value_next;
   logic [7:0] preload_reg;
   logic [7:0] preload_next;
   logic [7:0] timer_control_reg;
   logic [7:0] timer_control_next;
   tec8_pw_state_t pw_state_reg;
   tec8_pw_state_t pw_state_next;
   logic [`TEC8_IRQ_HI:0] irq_status_reg;
   logic [`TEC8_IRQ_HI:0] irq_status_next;
   logic [`TEC8_IRQ_HI:0] irq_enable_reg;
   logic [`TEC8_IRQ_HI:0] irq_enable_next;
   logic [`TEC8_IRQ_HI:0] irq_clear;
   logic irq_next;
   logic [7:0] rdata_next;
   tec8_mode_t op_mode_sel;
   logic tick_source_sel;
   logic count_enable_bit;
   logic edge_polarity_sel;
   logic [2:0] prescale_sel;
   logic wr_count;
   logic wr_ctrl;
   logic wr_clr;
   logic wr_ien;
   logic mode_tick;
   logic tick;
   logic full;
   logic ovf;
   logic start_edge;
   logic stop_edge;
   logic pw_done;

   if (ADDR_W < 3) begin : g_bad_addr
      $error("tec8_top needs an address of at least three bits");
   end

   // sub clock and event pin are brought onto the system clock
   tec8_sync #(
      .WIDTH(2)
   ) u_sync (
      .clock(clock),
      .rst_b(rst_b),
      .async_in({sub_clock, event_input_pin}),
      .sync_out({sub_s, pin_s})
   );

   // edge detection on the synchronised levels
   always_comb begin
      sub_prev_next = sub_s;
      pin_prev_next = pin_s;
      pin_rise = pin_s & ~pin_prev_reg;
      pin_fall = ~pin_s & pin_prev_reg;
      sub_fall = ~sub_s & sub_prev_reg;
   end

   // previous levels for edge detection
   always_ff @(posedge clock) begin
      if (!rst_b) begin
         sub_prev_reg <= 1'b0;
         pin_prev_reg <= 1'b0;
      end else begin
         sub_prev_reg <= sub_prev_next;
         pin_prev_reg <= pin_prev_next;
      end
   end

   // control fields
   always_comb begin
      op_mode_sel = tec8_mode_t'(timer_control_reg[`TEC8_CTL_MODE_HI:`TEC8_CTL_MODE_LO]);
      tick_source_sel = timer_control_reg[`TEC8_CTL_SRC];
      count_enable_bit = timer_control_reg[`TEC8_CTL_EN];
      edge_polarity_sel = timer_control_reg[`TEC8_CTL_POL];
      prescale_sel = timer_control_reg[`TEC8_CTL_PSC_HI:`TEC8_CTL_PSC_LO];
   end

   // prescaler input: every system clock, or each sub clock fall
   always_comb begin
      tp_tick = tick_source_sel ? sub_fall : 1'b1;
      presc_next = presc_reg;
      if (tp_tick) begin
         presc_next = presc_reg + `TEC8_PSC_ONE;
      end
   end

   // free running prescale counter
   always_ff @(posedge clock) begin
      if (!rst_b) begin
         presc_reg <= `TEC8_PSC_RESET;
      end else begin
         presc_reg <= presc_next;
      end
   end

   // stage k falls when the low k bits are all ones and the input ticks
   assign fall_vec[0] = tp_tick;
   for (genvar k = 1; k < `TEC8_DIV_N; k++) begin : g_div
      assign fall_vec[k] = tp_tick & (&presc_reg[k-1:0]);
   end

   // divided clock falling edge picked by prescale code
   assign int_tick = fall_vec[prescale_sel];

   // register port decode
   always_comb begin
      wr_count = bus_wr && (bus_addr == ADDR_W'(`TEC8_OFS_COUNT));
      wr_ctrl = bus_wr && (bus_addr == ADDR_W'(`TEC8_OFS_CTRL));
      wr_clr = bus_wr && (bus_addr == ADDR_W'(`TEC8_OFS_IRQ_CLR));
      wr_ien = bus_wr && (bus_addr == ADDR_W'(`TEC8_OFS_IRQ_EN));
   end

   // count tick source per mode and pulse edges
   always_comb begin
      start_edge = edge_polarity_sel ? pin_rise : pin_fall;
      stop_edge = edge_polarity_sel ? pin_fall : pin_rise;
      unique case (op_mode_sel)
         TEC8_MODE_NONE: mode_tick = 1'b0;
         TEC8_MODE_EVENT: mode_tick = edge_polarity_sel ? pin_fall : pin_rise;
         TEC8_MODE_TIMER: mode_tick = int_tick;
         TEC8_MODE_PULSE: mode_tick = (pw_state_reg == TEC8_PW_RUN) & int_tick;
      endcase
      tick = count_enable_bit & mode_tick;
      full = count_value_reg == `TEC8_CNT_FULL;
      ovf = tick & full;
      pw_done = count_enable_bit && (op_mode_sel == TEC8_MODE_PULSE) &&
                (pw_state_reg == TEC8_PW_RUN) && stop_edge;
   end

   // pulse width state: wait for start edge, run until stop edge
   always_comb begin
      pw_state_next = pw_state_reg;
      if (!count_enable_bit || op_mode_sel != TEC8_MODE_PULSE) begin
         pw_state_next = TEC8_PW_WAIT;
      end else begin
         unique case (pw_state_reg)
            TEC8_PW_WAIT: begin
               if (start_edge) begin
                  pw_state_next = TEC8_PW_RUN;
               end
            end
            TEC8_PW_RUN: begin
               if (stop_edge) begin
                  pw_state_next = TEC8_PW_WAIT;
               end
            end
            default: pw_state_next = TEC8_PW_WAIT;
         endcase
      end
   end

   // counter, preload and control next values
   always_comb begin
      count_value_next = count_value_reg;
      preload_next = preload_reg;
      timer_control_next = timer_control_reg;
      if (wr_count) begin
         preload_next = bus_wdata;
      end
      if (wr_count && !count_enable_bit) begin
         count_value_next = bus_wdata;
      end else if (ovf) begin
         count_value_next = preload_reg;
      end else if (tick) begin
         count_value_next = count_value_reg + `TEC8_CNT_ONE;
      end
      if (wr_ctrl) begin
         timer_control_next = bus_wdata;
      end else if (pw_done) begin
         timer_control_next[`TEC8_CTL_EN] = 1'b0;
      end
   end

   // counter state registers
   always_ff @(posedge clock) begin
      if (!rst_b) begin
         count_value_reg <= `TEC8_CNT_RESET;
         preload_reg <= `TEC8_CNT_RESET;
         timer_control_reg <= `TEC8_CTL_RESET;
         pw_state_reg <= TEC8_PW_WAIT;
      end else begin
         count_value_reg <= count_value_next;
         preload_reg <= preload_next;
         timer_control_reg <= timer_control_next;
         pw_state_reg <= pw_state_next;
      end
   end

   // sticky status, set wins over clear; level interrupt
   always_comb begin
      irq_clear = wr_clr ? bus_wdata[`TEC8_IRQ_HI:0] : `TEC8_IRQ_RESET;
      irq_status_next = irq_status_reg & ~irq_clear;
      irq_status_next[`TEC8_IRQ_OVF] = irq_status_next[`TEC8_IRQ_OVF] | ovf;
      irq_status_next[`TEC8_IRQ_PWD] = irq_status_next[`TEC8_IRQ_PWD] | pw_done;
      irq_enable_next = wr_ien ? bus_wdata[`TEC8_IRQ_HI:0] : irq_enable_reg;
      irq_next = |(irq_status_next & irq_enable_next);
   end

   // interrupt registers
   always_ff @(posedge clock) begin
      if (!rst_b) begin
         irq_status_reg <= `TEC8_IRQ_RESET;
         irq_enable_reg <= `TEC8_IRQ_RESET;
         irq <= 1'b0;
      end else begin
         irq_status_reg <= irq_status_next;
         irq_enable_reg <= irq_enable_next;
         irq <= irq_next;
      end
   end

   // read mux; unmapped and write-only offsets read zero
   always_comb begin
      rdata_next = `TEC8_DATA_ZERO;
      if (bus_rd) begin
         if (bus_addr == ADDR_W'(`TEC8_OFS_COUNT)) begin
            rdata_next = count_value_reg;
         end else if (bus_addr == ADDR_W'(`TEC8_OFS_CTRL)) begin
            rdata_next = timer_control_reg;
         end else if (bus_addr == ADDR_W'(`TEC8_OFS_IRQ_STAT)) begin
            rdata_next[`TEC8_IRQ_HI:0] = irq_status_reg;
         end else if (bus_addr == ADDR_W'(`TEC8_OFS_IRQ_EN)) begin
            rdata_next[`TEC8_IRQ_HI:0] = irq_enable_reg;
         end
      end
   end

   // read data stand one cycle after the strobe only
   always_ff @(posedge clock) begin
      if (!rst_b) begin
         bus_rdata <= `TEC8_DATA_ZERO;
      end else begin
         bus_rdata <= rdata_next;
      end
   end

   // counter checks
   property p_inc;
      @(posedge clock) disable iff (!rst_b)
      (tick && !full) |=> (count_value_reg == $past(count_value_reg) + `TEC8_CNT_ONE);
   endproperty
   a_inc: assert property (p_inc) else $error("count did not step by one");

   property p_ovf;
      @(posedge clock) disable iff (!rst_b)
      ovf |=> (count_value_reg == $past(preload_reg)) && irq_status_reg[`TEC8_IRQ_OVF];
   endproperty
   a_ovf: assert property (p_ovf) else $error("overflow did not reload or flag");

   property p_hold;
      @(posedge clock) disable iff (!rst_b)
      (!count_enable_bit && !wr_count) |=> $stable(count_value_reg);
   endproperty
   a_hold: assert property (p_hold) else $error("count moved while disabled");

   property p_wr_off;
      @(posedge clock) disable iff (!rst_b)
      (wr_count && !count_enable_bit) |=>
         (count_value_reg == $past(bus_wdata)) && (preload_reg == $past(bus_wdata));
   endproperty
   a_wr_off: assert property (p_wr_off) else $error("stopped write not loaded");

   property p_wr_on;
      @(posedge clock) disable iff (!rst_b)
      (wr_count && count_enable_bit && !tick) |=>
         $stable(count_value_reg) && (preload_reg == $past(bus_wdata));
   endproperty
   a_wr_on: assert property (p_wr_on) else $error("running write touched counter");

   property p_rd;
      @(posedge clock) disable iff (!rst_b)
      (bus_rd && bus_addr == ADDR_W'(`TEC8_OFS_COUNT)) |=> (bus_rdata == $past(count_value_reg));
   endproperty
   a_rd: assert property (p_rd) else $error("count read not live value");

   // mode checks
   property p_evt;
      @(posedge clock) disable iff (!rst_b)
      (count_enable_bit && op_mode_sel == TEC8_MODE_EVENT && !full &&
       (edge_polarity_sel ? pin_fall : pin_rise))
         |=> (count_value_reg == $past(count_value_reg) + `TEC8_CNT_ONE);
   endproperty
   a_evt: assert property (p_evt) else $error("event edge not counted");

   property p_psc0;
      @(posedge clock) disable iff (!rst_b)
      (count_enable_bit && op_mode_sel == TEC8_MODE_TIMER && !tick_source_sel &&
       prescale_sel == 3'h0 && !full)
         |=> (count_value_reg == $past(count_value_reg) + `TEC8_CNT_ONE);
   endproperty
   a_psc0: assert property (p_psc0) else $error("undivided timer missed a tick");

   property p_pw_wait;
      @(posedge clock) disable iff (!rst_b)
      (op_mode_sel == TEC8_MODE_PULSE && pw_state_reg == TEC8_PW_WAIT && !wr_count)
         |=> $stable(count_value_reg);
   endproperty
   a_pw_wait: assert property (p_pw_wait) else $error("pulse count ran before start");

   property p_pw_stop;
      @(posedge clock) disable iff (!rst_b)
      (pw_done && !wr_ctrl) |=> !count_enable_bit ##1 (pw_state_reg == TEC8_PW_WAIT);
   endproperty
   a_pw_stop: assert property (p_pw_stop) else $error("pulse end kept enable");

   // interrupt checks: level follows enabled sticky status
   property p_irq;
      @(posedge clock) disable iff (!rst_b)
      irq == |(irq_status_reg & irq_enable_reg);
   endproperty
   a_irq: assert property (p_irq) else $error("interrupt level not status and enable");
endmodule // tec8_top

// ==== sim/tec8_pin_src.sv ====
/*
 holds a behavioural source that drives the event pin with levels and pulses.
 assumes the bench calls its tasks and that each level lasts at least 3 clocks.
*/
`timescale 1ns/10ps
module tec8_pin_src (
   input wire logic clock,
   output logic pin
);
   initial pin = 1'b0;
   // drive a level right after an edge, then hold it
   task automatic set_level(input logic lvl, input int hold);
      @(posedge clock);
      pin <= lvl;
      repeat ((hold < 3) ? 3 : hold) @(posedge clock); // never shorter than the synchroniser needs
   endtask
   // one pulse away from the idle level and back
   task automatic pulse(input logic idle, input int width, input int gap);
      set_level(!idle, width);
      set_level(idle, gap);
   endtask
endmodule // tec8_pin_src

// ==== sim/tb_top.sv ====
/*
 holds the self-checking bench of the timer/event counter.
 assumes the register port of the design and a 40 MHz clock.
*/
`timescale 1ns/10ps
`include "tec8_map.svh"
module tb_top;
   import tec8_pkg::*;
   logic clock, rst_b, bus_wr, bus_rd, sub_clock, irq, event_input_pin;
   logic [2:0] bus_addr;
   logic [7:0] bus_wdata, bus_rdata, d, saved;
   logic [31:0] seed;
   int n_errors, samples_checked, k, n, w;
   tec8_top tec8_top_inst (.clock(clock), .rst_b(rst_b), .bus_addr(bus_addr), .bus_wdata(bus_wdata),
      .bus_wr(bus_wr), .bus_rd(bus_rd), .bus_rdata(bus_rdata), .sub_clock(sub_clock),
      .event_input_pin(event_input_pin), .irq(irq));
   tec8_pin_src tec8_pin_src_inst (.clock(clock), .pin(event_input_pin));
   // clocks: system clock and a sub clock of 8 system periods
   initial begin
      clock = 1'b0;
      forever #12.5 clock = ~clock;
   end
   initial begin
      sub_clock = 1'b0;
      forever #100 sub_clock = ~sub_clock;
   end
   // control byte and helpers
   function automatic logic [7:0] ctl(input logic [1:0] m, input logic s, input logic e, input logic p,
      input logic [2:0] c);
      return {m, s, e, p, c};
   endfunction
   function automatic logic [7:0] in_win(input logic [7:0] v, input int e, input int t);
      return {7'h00, (int'(v) >= e - t) && (int'(v) <= e + t)};
   endfunction
   function automatic int rnd(input int m);
      seed ^= seed << 13;
      seed ^= seed >> 17;
      seed ^= seed << 5;
      return int'(seed % m);
   endfunction
   // comparison and verdict
   task automatic check(input string what, input logic [7:0] seen, input logic [7:0] exp);
      samples_checked++;
      if (seen !== exp) begin
         $display("ERROR %s expected %h seen %h", what, exp, seen);
         n_errors++;
      end
   endtask
   task automatic close_out();
      $display("errors %0d checks %0d", n_errors, samples_checked);
      if (n_errors == 0 && samples_checked > 0) begin
         $display("All checks passed");
      end else begin
         $display("Checks failed");
      end
      $finish;
   endtask
   // register port cycles
   task automatic wr(input logic [2:0] a, input logic [7:0] v);
      @(posedge clock);
      bus_addr <= a;
      bus_wdata <= v;
      bus_wr <= 1'b1;
      @(posedge clock);
      bus_wr <= 1'b0;
   endtask
   task automatic rd(input logic [2:0] a, output logic [7:0] v);
      @(posedge clock);
      bus_addr <= a;
      bus_rd <= 1'b1;
      @(posedge clock);
      bus_rd <= 1'b0;
      #1 v = bus_rdata; // data stand only in the cycle after the read
   endtask
   task automatic rd_chk(input logic [2:0] a, input logic [7:0] exp, input string what);
      logic [7:0] v;
      rd(a, v);
      check(what, v, exp);
   endtask
   task automatic wait_irq(input int bound);
      int i;
      for (i = 0; i < bound && irq !== 1'b1; i++) @(posedge clock);
      if (irq !== 1'b1) begin
         $display("ERROR irq wait expected 1 seen %b", irq);
         n_errors++;
         close_out();
      end
   endtask
   // watchdog on the whole run
   initial begin
      #2500000;
      n_errors++;
      close_out();
   end
   // main sequence
   initial begin
      rst_b = 1'b0;
      bus_wr = 1'b0;
      bus_rd = 1'b0;
      bus_addr = 3'h0;
      bus_wdata = 8'h00;
      n_errors = 0;
      samples_checked = 0;
      seed = 32'h019d8a00;
      repeat (5) @(posedge clock);
      rst_b <= 1'b1;
      // reset values, unmapped and write-only places
      rd_chk(`TEC8_OFS_COUNT, 8'h00, "count reset");
      rd_chk(`TEC8_OFS_CTRL, 8'h08, "control reset");
      rd_chk(`TEC8_OFS_IRQ_STAT, 8'h00, "status reset");
      rd_chk(`TEC8_OFS_IRQ_EN, 8'h00, "enable reset");
      rd_chk(`TEC8_OFS_IRQ_CLR, 8'h00, "clear reads zero");
      rd_chk(3'h7, 8'h00, "unmapped read");
      saved = 8'(rnd(256));
      wr(`TEC8_OFS_COUNT, saved);
      rd_chk(`TEC8_OFS_COUNT, saved, "stopped write");
      // prescale codes, sub clock source and the unused mode over timed windows
      for (int i = 0; i < 10; i++) begin
         k = (i == 8) ? 512 : (64 << ((i < 8) ? i : 0));
         wr(`TEC8_OFS_COUNT, 8'h00);
         wr(`TEC8_OFS_CTRL, ctl((i == 9) ? 2'h0 : 2'h2, i == 8, 1'b1, 1'b0, 3'((i < 8) ? i : 0)));
         repeat (k - 2) @(posedge clock);
         wr(`TEC8_OFS_CTRL, ctl(2'h2, i == 8, 1'b0, 1'b0, 3'h0));
         rd(`TEC8_OFS_COUNT, d);
         check("ticks in window", in_win(d, (i == 9) ? 0 : 64, (i == 9) ? 0 : 2), 8'h01);
      end
      wr(`TEC8_OFS_CTRL, ctl(2'h2, 1'b0, 1'b1, 1'b0, 3'h0));
      wr(`TEC8_OFS_CTRL, ctl(2'h2, 1'b0, 1'b0, 1'b0, 3'h0));
      rd(`TEC8_OFS_COUNT, d);
      check("ticks before halt", d, 8'h02);
      repeat (20) @(posedge clock);
      rd_chk(`TEC8_OFS_COUNT, d, "halted count");
      // event mode, both polarities, source and prescale set to unlikely values
      for (int p = 0; p < 2; p++) begin
         n = 3 + rnd(6);
         wr(`TEC8_OFS_CTRL, 8'h00);
         wr(`TEC8_OFS_COUNT, 8'h00);
         wr(`TEC8_OFS_CTRL, ctl(2'h1, 1'b1, 1'b1, p[0], 3'h7));
         repeat (n) tec8_pin_src_inst.pulse(1'b0, 2 + rnd(4), 3 + rnd(4));
         repeat (6) @(posedge clock);
         rd_chk(`TEC8_OFS_COUNT, 8'(n), "event count");
      end
      // pulse width mode, both polarities, idle level opposite the start edge
      for (int p = 0; p < 2; p++) begin
         wr(`TEC8_OFS_CTRL, ctl(2'h0, 1'b0, 1'b0, p[0], 3'h0));
         tec8_pin_src_inst.set_level(!p[0], 6);
         wr(`TEC8_OFS_IRQ_CLR, 8'h03);
         wr(`TEC8_OFS_COUNT, 8'h00);
         wr(`TEC8_OFS_CTRL, ctl(2'h3, 1'b0, 1'b1, p[0], 3'h0));
         repeat (20) @(posedge clock);
         rd_chk(`TEC8_OFS_COUNT, 8'h00, "held before start");
         w = 20 + rnd(40);
         tec8_pin_src_inst.pulse(!p[0], w, 12);
         rd_chk(`TEC8_OFS_CTRL, ctl(2'h3, 1'b0, 1'b0, p[0], 3'h0), "enable self-cleared");
         rd(`TEC8_OFS_COUNT, saved);
         check("pulse width", in_win(saved, w, 3), 8'h01);
         rd_chk(`TEC8_OFS_IRQ_STAT, 8'h02, "pulse done status");
         tec8_pin_src_inst.pulse(!p[0], 10, 10);
         rd_chk(`TEC8_OFS_COUNT, saved, "later edges ignored");
      end
      // overflow, running write, interrupt mask and clear
      wr(`TEC8_OFS_IRQ_CLR, 8'h03);
      wr(`TEC8_OFS_IRQ_EN, 8'h01);
      wr(`TEC8_OFS_COUNT, 8'h00);
      wr(`TEC8_OFS_CTRL, ctl(2'h2, 1'b0, 1'b1, 1'b0, 3'h4));
      wr(`TEC8_OFS_COUNT, 8'ha0);
      rd(`TEC8_OFS_COUNT, d);
      check("running write leaves counter", {7'h00, d < 8'h10}, 8'h01);
      wait_irq(4400);
      rd(`TEC8_OFS_COUNT, d);
      check("reload after overflow", in_win(d, 8'ha0, 1), 8'h01);
      rd_chk(`TEC8_OFS_IRQ_STAT, 8'h01, "overflow status");
      wr(`TEC8_OFS_IRQ_EN, 8'h00);
      @(posedge clock);
      #1 check("irq masked", {7'h00, irq}, 8'h00);
      wr(`TEC8_OFS_IRQ_EN, 8'h01);
      @(posedge clock);
      #1 check("irq unmasked", {7'h00, irq}, 8'h01);
      wr(`TEC8_OFS_IRQ_CLR, 8'h01);
      @(posedge clock);
      #1 check("irq cleared", {7'h00, irq}, 8'h00);
      rd_chk(`TEC8_OFS_IRQ_STAT, 8'h00, "status cleared");
      close_out();
   end
endmodule // tb_top
